// ==== core/ipc_ctrl.sv ====
// Idle and power-down controller: machine-cycle phase, mode control,
// clock gating, wake-up and reset-cause flags.
// Assumes inputs synchronous to mclk; the core obeys the clock enables.
//
// Behaviour
// - machine cycle is four states, first to fourth, fixed order.
// - one op-code fetch strobe per machine cycle.
// - single-cycle ops finish in one cycle; external move takes two.
// - writing idle bit enters idle after that instruction completes.
// - idle gates CPU clock; peripheral clocks keep running.
// - idle freezes CPU registers and port levels.
// - enabled interrupt clears idle bit, wakes, runs service routine.
// - reset from idle zeroes program counter, restarts at once.
// - watchdog counts in idle; time-out wakes, reset 512 clocks later.
// - reset ending idle suppresses the next instruction.
// - writing power-down bit stops CPU, peripheral and oscillator clocks after that instruction.
// - ports keep driving register values in power-down.
// - low reset pin ends power-down, restarts clock, start at zero.
// - external-clocked watchdog cannot reset out of power-down.
// - power-down left by external interrupt, brownout, or ADC done.
// - enabled external interrupt with global enable wakes, resumes.
// - low-power brownout select one, detect zero: RC clock runs.
// - most state resets alike; cause flags depend on source.
// - reset pin sampled in fourth state; held two cycles after.
`include "ipc_cfg.svh"
module ipc_ctrl #(
  parameter int WDT_GRACE = `IPC_WDT_GRACE_CLK
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata_q,
  input wire logic ext_rst_n,
  input wire logic por_n,
  input wire ipc_pkg::ipc_wake_t wake,
  input wire logic ext_int_en,
  input wire logic op_single,
  input wire logic op_ext_move,
  input wire logic wdt_rc_clk,
  output ipc_pkg::ipc_clk_t clk_en_q,
  output logic fetch_q,
  output logic last_cycle_q,
  output logic sys_reset_q,
  output logic [15:0] reset_pc_q,
  output logic skip_next_q,
  output logic port_hold_q,
  output logic wdt_int_q,
  output logic [1:0] mode_q
);
  ipc_pkg::ipc_mode_t mode_s;
  logic [`IPC_STATE_W-1:0] state_w;
  logic fourth_w;
  logic ext_rst_w;
  logic pd_exit_w;
  logic [1:0] pcon_q;
  logic [7:0] gie_q;
  logic [7:0] aux_q;
  logic [7:0] wdcfg_q;
  logic [2:0] cause_q;
  logic wdt_timeout;
  logic wdt_clear;
  logic [9:0] wdt_cnt_q;
  logic wdt_armed_q;
  logic wdt_reset;
  logic [1:0] cyc_left_q;
  logic last_now;
  logic idle_go;
  logic pd_go;
  logic int_wake;
  logic pd_wake;
  logic any_reset;
  logic por_seen_q;

  // Phase counter frozen only in power-down
  ipc_phase #(
    .STATE_W(`IPC_STATE_W)
  ) u_phase (
    .mclk(mclk),
    .rst_b(rst_b),
    .en(mode_s != ipc_pkg::IPC_PDOWN),
    .state_q(state_w),
    .fourth_state(fourth_w)
  );

  ipc_rstfilt u_rstfilt (
    .mclk(mclk),
    .rst_b(rst_b),
    .sample(fourth_w),
    .ext_rst_n(ext_rst_n),
    .pd_active(mode_s == ipc_pkg::IPC_PDOWN),
    .reset_q(ext_rst_w),
    .pd_exit(pd_exit_w)
  );

  // Reset wins over everything; power-down wins over idle
  assign wdt_clear = wr && (addr == `IPC_ADDR_D);
  assign wdt_timeout = wdt_cnt_q == `IPC_WDT_TOP;
  assign any_reset = ext_rst_w || !por_n || wdt_reset || pd_exit_w;
  assign int_wake = gie_q[`IPC_BIT_GIE] &&
                    (wake.any_int || wdt_int_q);
  assign pd_wake = (gie_q[`IPC_BIT_GIE] && ext_int_en && wake.ext_int)
                   || wake.brownout
                   || (wake.adc_done && clk_en_q.rc_clk_en);
  assign idle_go = pcon_q[`IPC_BIT_IDLE] && !pcon_q[`IPC_BIT_PD];
  assign pd_go = pcon_q[`IPC_BIT_PD];
  // Fourth state of an op's final machine cycle; a two-cycle move
  // ends only when its extra cycle has been counted down
  assign last_now = fourth_w && mode_s == ipc_pkg::IPC_RUN &&
                    (cyc_left_q == 2'h1 ||
                     (cyc_left_q == 2'h0 && !op_ext_move));

  // Instruction length tracking: mode change waits for last cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_left_q <= 2'h0;
    end else if (any_reset) begin
      cyc_left_q <= 2'h0;
    end else if (fourth_w && mode_s == ipc_pkg::IPC_RUN) begin
      if (cyc_left_q != 2'h0) begin
        cyc_left_q <= cyc_left_q - 2'h1;
      end else if (op_ext_move) begin
        cyc_left_q <= 2'h1;
      end else if (!op_single) begin
        cyc_left_q <= 2'h0;
      end
    end
  end

  // Fetch strobe once per machine cycle, last-cycle flag beside it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_q <= 1'b0;
      last_cycle_q <= 1'b0;
    end else begin
      fetch_q <= (mode_s == ipc_pkg::IPC_RUN) &&
                 (state_w == `IPC_FIRST_STATE);
      last_cycle_q <= last_now;
    end
  end

  // Mode state machine
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mode_s <= ipc_pkg::IPC_RESET;
    end else begin
      unique case (mode_s)
        ipc_pkg::IPC_RUN: begin
          if (any_reset) begin
            mode_s <= ipc_pkg::IPC_RESET;
          end else if (last_now && pd_go) begin
            mode_s <= ipc_pkg::IPC_PDOWN;
          end else if (last_now && idle_go) begin
            mode_s <= ipc_pkg::IPC_IDLE;
          end
        end
        ipc_pkg::IPC_IDLE: begin
          if (any_reset) begin
            mode_s <= ipc_pkg::IPC_RESET;
          end else if (int_wake) begin
            mode_s <= ipc_pkg::IPC_RUN;
          end
        end
        ipc_pkg::IPC_PDOWN: begin
          // RC-clocked watchdog may still reset out of power-down
          if (any_reset || wake.brownout) begin
            mode_s <= ipc_pkg::IPC_RESET;
          end else if (pd_wake) begin
            mode_s <= ipc_pkg::IPC_RUN;
          end
        end
        ipc_pkg::IPC_RESET: begin
          if (!any_reset) begin
            mode_s <= ipc_pkg::IPC_RUN;
          end
        end
      endcase
    end
  end

  // Request bits: hardware wake clears them, software sets them
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pcon_q <= 2'h0;
    end else if (any_reset || mode_s == ipc_pkg::IPC_RESET) begin
      pcon_q <= 2'h0;
    end else if (mode_s == ipc_pkg::IPC_IDLE && int_wake) begin
      pcon_q[`IPC_BIT_IDLE] <= 1'b0;
    end else if (mode_s == ipc_pkg::IPC_PDOWN && pd_wake) begin
      // Both bits go, else a joint request would fall into idle
      pcon_q <= 2'h0;
    end else if (wr && addr == `IPC_ADDR_A) begin
      pcon_q <= wdata[1:0];
    end
  end

  // Software configuration registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gie_q <= 8'h00;
      aux_q <= 8'h00;
      wdcfg_q <= 8'h00;
    end else if (any_reset) begin
      gie_q <= 8'h00;
      aux_q <= 8'h00;
      wdcfg_q <= 8'h00;
    end else if (wr) begin
      if (addr == `IPC_ADDR_B) begin
        gie_q <= wdata;
      end
      if (addr == `IPC_ADDR_C) begin
        aux_q <= wdata;
      end
      if (addr == `IPC_ADDR_D) begin
        wdcfg_q <= wdata;
      end
    end
  end

  // Watchdog keeps counting in idle; in power-down it stops unless wdt_rc_clk is set
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_cnt_q <= 10'h000;
    end else if (any_reset || wdt_clear) begin
      wdt_cnt_q <= 10'h000;
    end else if (wdcfg_q[`IPC_BIT_WDEN] &&
                 (mode_s != ipc_pkg::IPC_PDOWN || wdt_rc_clk) &&
                 !wdt_timeout) begin
      wdt_cnt_q <= wdt_cnt_q + 10'h001;
    end
  end

  // Grace period after time-out; set wins over software clear
  logic [9:0] grace_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_int_q <= 1'b0;
      wdt_armed_q <= 1'b0;
      grace_q <= 10'h000;
    end else if (any_reset) begin
      wdt_int_q <= 1'b0;
      wdt_armed_q <= 1'b0;
      grace_q <= 10'h000;
    end else if (wdt_timeout && !wdt_armed_q) begin
      wdt_int_q <= 1'b1;
      wdt_armed_q <= 1'b1;
      grace_q <= 10'(WDT_GRACE - 1);
    end else if (wdt_clear) begin
      wdt_int_q <= 1'b0;
      wdt_armed_q <= 1'b0;
    end else if (wdt_armed_q && grace_q != 10'h000) begin
      grace_q <= grace_q - 10'h001;
    end
  end
  assign wdt_reset = wdt_armed_q && grace_q == 10'h000 &&
                     wdcfg_q[`IPC_BIT_WRSTEN];

  // Cause flags survive reset; power-on, watchdog and power-down brownout each set their own, the reset pin sets none
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cause_q <= 3'h0;
      por_seen_q <= 1'b0;
    end else begin
      por_seen_q <= 1'b1;
      if (!por_seen_q || !por_n) begin
        cause_q <= 3'h1;
      end else if (wdt_reset) begin
        cause_q[`IPC_CAUSE_WDT] <= 1'b1;
      end else if (wake.brownout && mode_s == ipc_pkg::IPC_PDOWN) begin
        cause_q[`IPC_CAUSE_BOR] <= 1'b1;
      end else if (wr && addr == `IPC_ADDR_E) begin
        cause_q <= cause_q & ~wdata[2:0];
      end
    end
  end

  // Clock enables, reset outputs and port hold
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clk_en_q <= '0;
      sys_reset_q <= 1'b1;
      reset_pc_q <= `IPC_RESET_PC;
      skip_next_q <= 1'b0;
      port_hold_q <= 1'b0;
      mode_q <= ipc_pkg::IPC_RESET;
    end else begin
      clk_en_q.cpu_clk_en <= mode_s == ipc_pkg::IPC_RUN;
      clk_en_q.periph_clk_en <= mode_s != ipc_pkg::IPC_PDOWN;
      clk_en_q.osc_en <= mode_s != ipc_pkg::IPC_PDOWN;
      clk_en_q.rc_clk_en <= mode_s == ipc_pkg::IPC_PDOWN &&
                            aux_q[`IPC_BIT_LPBS] &&
                            !aux_q[`IPC_BIT_BDC];
      // Same source as mode_q, so the two never disagree
      sys_reset_q <= mode_s == ipc_pkg::IPC_RESET;
      reset_pc_q <= `IPC_RESET_PC;
      // Suppress stale instruction after idle is broken by reset
      if (mode_s == ipc_pkg::IPC_IDLE && any_reset) begin
        skip_next_q <= 1'b1;
      end else if (mode_s == ipc_pkg::IPC_RUN) begin
        skip_next_q <= 1'b0;
      end
      port_hold_q <= mode_s == ipc_pkg::IPC_IDLE ||
                     mode_s == ipc_pkg::IPC_PDOWN;
      mode_q <= mode_s;
    end
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      unique case (addr)
        `IPC_ADDR_A: rdata_q <= {6'h00, pcon_q};
        `IPC_ADDR_B: rdata_q <= gie_q;
        `IPC_ADDR_C: rdata_q <= aux_q;
        `IPC_ADDR_D: rdata_q <= {wdt_int_q, wdcfg_q[6:0]};
        `IPC_ADDR_E: rdata_q <= {3'h0, state_w, cause_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
endmodule // ipc_ctrl

// ==== include/ipc_cfg.svh ====
// Constants for the idle and power-down controller.
// Assumes inclusion by bare name; no processes here.
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH
`define IPC_STATE_W 2
`define IPC_FIRST_STATE 2'h0
`define IPC_FOURTH_STATE 2'h3
`define IPC_RST_MIN_CYC 2
`define IPC_RST_HOLD_CYC 2
`define IPC_WDT_GRACE_CLK 512
`define IPC_WDT_TOP 10'h3FF
`define IPC_ADDR_A 4'h0
`define IPC_ADDR_B 4'h1
`define IPC_ADDR_C 4'h2
`define IPC_ADDR_D 4'h3
`define IPC_ADDR_E 4'h4
`define IPC_BIT_IDLE 0
`define IPC_BIT_PD 1
`define IPC_BIT_GIE 0
`define IPC_BIT_LPBS 0
`define IPC_BIT_BDC 1
`define IPC_BIT_WDEN 2
`define IPC_BIT_WRSTEN 3
`define IPC_CAUSE_POR 0
`define IPC_CAUSE_WDT 1
`define IPC_CAUSE_BOR 2
`define IPC_RESET_PC 16'h0000
`endif

// ==== include/ipc_pkg.sv ====
// Types shared by the power-mode controller files.
// Assumes ipc_cfg.svh constants are included alongside.
package ipc_pkg;
  typedef enum logic [1:0] {
    IPC_RUN,
    IPC_IDLE,
    IPC_PDOWN,
    IPC_RESET
  } ipc_mode_t;
  typedef struct packed {
    logic ext_int;
    logic brownout;
    logic adc_done;
    logic any_int;
  } ipc_wake_t;
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_en;
    logic rc_clk_en;
  } ipc_clk_t;
endpackage

// ==== core/ipc_phase.sv ====
// Four-state machine-cycle phase counter.
// Assumes one clock; enable low freezes it (power-down).
`include "ipc_cfg.svh"
module ipc_phase #(
  parameter int STATE_W = `IPC_STATE_W
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic en,
  output logic [STATE_W-1:0] state_q,
  output logic fourth_state
);
  // Fixed first-to-fourth order, wraps each machine cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= `IPC_FIRST_STATE;
    end else if (en) begin
      state_q <= STATE_W'(state_q + 1'b1);
    end
  end
  assign fourth_state = en && (state_q == `IPC_FOURTH_STATE);
endmodule // ipc_phase

// ==== core/ipc_rstfilt.sv ====
// External reset pin qualifier, sampled once per machine cycle.
// Assumes pin synchronous to mclk; sample is the fourth-state strobe.
`include "ipc_cfg.svh"
module ipc_rstfilt #(
  parameter int MIN_CYC = `IPC_RST_MIN_CYC,
  parameter int HOLD_CYC = `IPC_RST_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sample,
  input wire logic ext_rst_n,
  input wire logic pd_active,
  output logic reset_q,
  output logic pd_exit
);
  logic [2:0] low_cnt_q;
  logic [2:0] hold_cnt_q;
  // Pin counted low over successive machine cycles
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_q <= 3'h0;
    end else if (sample) begin
      if (ext_rst_n) begin
        low_cnt_q <= 3'h0;
      end else if (low_cnt_q < 3'(MIN_CYC)) begin
        low_cnt_q <= low_cnt_q + 3'h1;
      end
    end
  end
  // Reset held while pin low, then two more machine cycles
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hold_cnt_q <= 3'h0;
    end else if (sample) begin
      if (!ext_rst_n && low_cnt_q + 3'h1 >= 3'(MIN_CYC)) begin
        hold_cnt_q <= 3'(HOLD_CYC);
      end else if (hold_cnt_q != 3'h0) begin
        hold_cnt_q <= hold_cnt_q - 3'h1;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reset_q <= 1'b0;
    end else begin
      reset_q <= (hold_cnt_q != 3'h0);
    end
  end
  // Clock is stopped in power-down, so a plain low level wakes
  assign pd_exit = pd_active && !ext_rst_n;
endmodule // ipc_rstfilt

// ==== bench/ipc_ctrl_properties.sv ====
// Port checker for the power-mode controller.
// Assumes bind into ipc_ctrl; single mclk domain.
module ipc_ctrl_chk #(
  parameter int WDT_GRACE = 512
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic rd,
  input wire logic ext_rst_n,
  input wire ipc_pkg::ipc_clk_t clk_en_q,
  input wire logic fetch_q,
  input wire logic sys_reset_q,
  input wire logic [15:0] reset_pc_q,
  input wire logic [7:0] rdata_q,
  input wire logic [1:0] mode_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Fetch strobes never closer than one four-state cycle
  fetch_space_a: assert property (
    fetch_q |=> !fetch_q ##1 !fetch_q ##1 !fetch_q)
    else $error("fetch strobes too close");
  reset_pc_a: assert property (
    sys_reset_q |-> reset_pc_q == 16'h0000)
    else $error("restart address not zero");
  reset_mode_a: assert property (
    sys_reset_q |-> mode_q == ipc_pkg::IPC_RESET)
    else $error("reset without reset mode");
  // Settled idle: core clock off, peripherals still fed
  idle_gate_a: assert property (
    mode_q == ipc_pkg::IPC_IDLE && $past(mode_q) == ipc_pkg::IPC_IDLE
    |-> !clk_en_q.cpu_clk_en && clk_en_q.periph_clk_en)
    else $error("idle clock gating wrong");
  pdown_stop_a: assert property (
    mode_q == ipc_pkg::IPC_PDOWN && $past(mode_q) == ipc_pkg::IPC_PDOWN
    |-> !clk_en_q.cpu_clk_en && !clk_en_q.periph_clk_en && !clk_en_q.osc_en)
    else $error("clock running in power-down");
  pdown_exit_a: assert property (
    mode_q == ipc_pkg::IPC_PDOWN && !ext_rst_n
    |-> ##[1:4] mode_q != ipc_pkg::IPC_PDOWN)
    else $error("reset pin did not end power-down");
  unmapped_read_a: assert property (
    rd && addr > 4'h4 |=> rdata_q == 8'h00)
    else $error("unmapped read not zero");
  read_quiet_a: assert property (
    !$past(rd) |-> rdata_q == 8'h00)
    else $error("read data outside answer cycle");
endmodule // ipc_ctrl_chk

bind ipc_ctrl ipc_ctrl_chk #(.WDT_GRACE(WDT_GRACE)) i_chk (
  .mclk(mclk), .rst_b(rst_b), .addr(addr), .rd(rd),
  .ext_rst_n(ext_rst_n), .clk_en_q(clk_en_q), .fetch_q(fetch_q),
  .sys_reset_q(sys_reset_q), .reset_pc_q(reset_pc_q),
  .rdata_q(rdata_q), .mode_q(mode_q));

// ==== bench/ipc_core_model.sv ====
// Core stand-in: reports the kind of op in flight.
// Assumes the controller samples op kind in the fourth state.
module ipc_core_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic heavy,
  input wire ipc_pkg::ipc_clk_t clk_en_q,
  output logic op_single,
  output logic op_ext_move
);
  timeunit 1ns;
  timeprecision 1ns;
  // Frozen while core clock is gated, as a real core would be
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      op_single <= 1'b1;
      op_ext_move <= 1'b0;
    end else if (clk_en_q.cpu_clk_en) begin
      op_single <= !heavy;
      op_ext_move <= heavy;
    end
  end
endmodule // ipc_core_model

// ==== bench/idle_powerdown_controller_test.sv ====
// Bench for the power-mode controller: one task per scenario.
// Assumes ipc_ctrl, its package and the bound checker are compiled.
module idle_powerdown_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ext_rst_n = 1'b1;
  logic por_n = 1'b1;
  ipc_pkg::ipc_wake_t wake = '0;
  logic ext_int_en = 1'b0;
  logic heavy = 1'b0;
  logic op_single;
  logic op_ext_move;
  logic [7:0] rdata_q;
  ipc_pkg::ipc_clk_t clk_en_q;
  logic fetch_q;
  logic last_cycle_q;
  logic sys_reset_q;
  logic [1:0] mode_q;
  logic skip_next_q;
  logic port_hold_q;
  logic wdt_int_q;
  logic [7:0] rv;
  localparam int GRACE = 8;
  int bad_count = 0;
  int compares = 0;
  int nf;
  int nl;

  // Even duty, only the rising edge is used inside
  always #5 mclk = ~mclk;

  ipc_ctrl #(.WDT_GRACE(GRACE)) i_dut (
    .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .ext_rst_n(ext_rst_n), .por_n(por_n),
    .wake(wake), .ext_int_en(ext_int_en), .op_single(op_single),
    .op_ext_move(op_ext_move), .wdt_rc_clk(1'b0), .clk_en_q(clk_en_q),
    .fetch_q(fetch_q), .last_cycle_q(last_cycle_q),
    .sys_reset_q(sys_reset_q), .reset_pc_q(), .skip_next_q(skip_next_q),
    .port_hold_q(port_hold_q), .wdt_int_q(wdt_int_q), .mode_q(mode_q));

  ipc_core_model i_core (
    .mclk(mclk), .rst_b(rst_b), .heavy(heavy), .clk_en_q(clk_en_q),
    .op_single(op_single), .op_ext_move(op_ext_move));

  task automatic report_and_stop();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Answer stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata_q;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Bounded wait; a stuck mode ends the run
  task automatic wait_mode(input logic [1:0] m);
    int n;
    n = 0;
    while (mode_q !== m && n < 200) begin
      step(1);
      n++;
    end
    if (mode_q !== m) begin
      chk("mode wait", 16'(m), 16'(mode_q));
      report_and_stop();
    end
  endtask

  // 32 clocks is a whole number of machine cycles, phase-free
  task automatic count_pulses();
    nf = 0;
    nl = 0;
    repeat (32) begin
      step(1);
      nf += (fetch_q === 1'b1);
      nl += (last_cycle_q === 1'b1);
    end
  endtask

  task automatic t_phase();
    count_pulses();
    chk("fetches", 16'h0008, 16'(nf));
    chk("single ops", 16'h0008, 16'(nl));
    heavy <= 1'b1;
    step(16);
    count_pulses();
    chk("ext moves", 16'h0004, 16'(nl));
    heavy <= 1'b0;
  endtask

  task automatic t_regs();
    wr_reg(4'h1, 8'h01);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'h1, rv);
    chk("int enable", 16'h0001, 16'(rv));
    rd_reg(4'hF, rv);
    chk("unmapped", 16'h0000, 16'(rv));
  endtask

  task automatic t_idle();
    wr_reg(4'h0, 8'h01);
    wait_mode(ipc_pkg::IPC_IDLE);
    step(2);
    chk("idle cpu clk", 16'h0000, 16'(clk_en_q.cpu_clk_en));
    chk("idle periph clk", 16'h0001, 16'(clk_en_q.periph_clk_en));
    wake.any_int <= 1'b1;
    wait_mode(ipc_pkg::IPC_RUN);
    wake.any_int <= 1'b0;
    rd_reg(4'h0, rv);
    chk("idle bit", 16'h0000, 16'(rv[0]));
    // Second idle, this time broken by the reset pin
    wr_reg(4'h0, 8'h01);
    wait_mode(ipc_pkg::IPC_IDLE);
    chk("idle port hold", 16'h0001, 16'(port_hold_q));
    ext_rst_n <= 1'b0;
    wait_mode(ipc_pkg::IPC_RESET);
    chk("skip after idle", 16'h0001, 16'(skip_next_q));
    ext_rst_n <= 1'b1;
    wait_mode(ipc_pkg::IPC_RUN);
  endtask

  task automatic t_pdown();
    wr_reg(4'h1, 8'h01);
    wr_reg(4'h2, 8'h01);
    ext_int_en <= 1'b1;
    wr_reg(4'h0, 8'h03);
    wait_mode(ipc_pkg::IPC_PDOWN);
    step(2);
    chk("pdown clocks", 16'h0001, 16'(clk_en_q));
    chk("pdown port hold", 16'h0001, 16'(port_hold_q));
    wake.ext_int <= 1'b1;
    wait_mode(ipc_pkg::IPC_RUN);
    wake.ext_int <= 1'b0;
    wr_reg(4'h2, 8'h02);
    wr_reg(4'h0, 8'h02);
    wait_mode(ipc_pkg::IPC_PDOWN);
    step(2);
    chk("rc clk", 16'h0000, 16'(clk_en_q.rc_clk_en));
    ext_rst_n <= 1'b0;
    wait_mode(ipc_pkg::IPC_RESET);
    ext_rst_n <= 1'b1;
    wait_mode(ipc_pkg::IPC_RUN);
  endtask

  // Short pulse ignored; long one resets and lingers
  task automatic t_ext_rst();
    int hits;
    hits = 0;
    ext_rst_n <= 1'b0;
    step(2);
    ext_rst_n <= 1'b1;
    repeat (16) begin
      step(1);
      hits += (sys_reset_q === 1'b1);
    end
    chk("short reset", 16'h0000, 16'(hits));
    ext_rst_n <= 1'b0;
    step(12);
    chk("long reset", 16'h0001, 16'(sys_reset_q));
    ext_rst_n <= 1'b1;
    step(4);
    chk("reset hold", 16'h0001, 16'(sys_reset_q));
    wait_mode(ipc_pkg::IPC_RUN);
    rd_reg(4'h1, rv);
    chk("enable after reset", 16'h0000, 16'(rv));
  endtask

  // Time-out raises the flag, reset follows after the grace count
  task automatic t_wdt();
    int n;
    n = 0;
    wr_reg(4'h4, 8'h07);
    wr_reg(4'h3, 8'h0C);
    step(1020);
    while (wdt_int_q !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    chk("wdt flag", 16'h0001, 16'(wdt_int_q));
    n = 0;
    while (wdt_int_q === 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    chk("wdt grace", 16'(GRACE), 16'(n));
    wait_mode(ipc_pkg::IPC_RESET);
    wait_mode(ipc_pkg::IPC_RUN);
    rd_reg(4'h4, rv);
    chk("wdt cause", 16'h0002, 16'(rv[2:0]));
  endtask

  // Flag cleared first, so only the new power-on can set it
  task automatic t_por();
    wr_reg(4'h4, 8'h07);
    por_n <= 1'b0;
    step(10);
    por_n <= 1'b1;
    wait_mode(ipc_pkg::IPC_RUN);
    rd_reg(4'h4, rv);
    chk("por flag", 16'h0001, 16'(rv[0]));
    wr_reg(4'h4, 8'h01);
    rd_reg(4'h4, rv);
    chk("por flag clear", 16'h0000, 16'(rv[0]));
  endtask

  initial begin
    step(5);
    rst_b <= 1'b1;
    wait_mode(ipc_pkg::IPC_RUN);
    chk("reset released", 16'h0000, 16'(sys_reset_q));
    t_phase();
    t_regs();
    t_idle();
    t_pdown();
    t_ext_rst();
    t_wdt();
    t_por();
    report_and_stop();
  end
endmodule // idle_powerdown_controller_test
